// ==== rtl/spc_pkg.sv ====
// Package: constants, modes and key and status structs of the single preset counter
package spc_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int CNT_W  = 20;
  localparam int DUR_W  = 14;
  localparam int CW     = 24;

  // Timed output unit 10 ms, default 0.1 s
  localparam int TICK_MS        = 10;
  localparam int TICK_CYC       = (CLK_HZ / 1000) * TICK_MS;
  localparam logic [DUR_W-1:0] DUR_MIN     = 14'h0001;
  localparam logic [DUR_W-1:0] DUR_MAX     = 14'h270f;
  localparam logic [DUR_W-1:0] DUR_DEFAULT = 14'h000a;
  localparam logic [CNT_W-1:0] PRESET_DEFAULT = 20'h001f4;

  // Remote clear must act within 10 ms; filter is 1 ms
  localparam int CLR_MS      = 10;
  localparam int FILT_US     = 1000;
  localparam int FILT_CYC    = (CLK_HZ / 1_000_000) * FILT_US;
  // Pulse input max rate 50 Hz: 2 ms debounce is well inside a half period
  localparam int DEB_US      = 2000;
  localparam int DEB_CYC     = (CLK_HZ / 1_000_000) * DEB_US;

  typedef enum logic [3:0] {
    SPC_MODE_UP_AUTO_AFTER  = 4'h6,
    SPC_MODE_DN_LATCH       = 4'h8,
    SPC_MODE_DN_TIMED_MAN   = 4'h9,
    SPC_MODE_DN_AUTO_AT     = 4'hc,
    SPC_MODE_DN_AUTO_AFTER  = 4'he
  } spc_mode_t;

  typedef struct packed {
    logic            load_preset;
    logic            load_dur;
    logic            out_test;
    logic            ack_fault;
    logic [CNT_W-1:0] preset;
    logic [DUR_W-1:0] dur;
  } spc_keys_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             out;
    logic             fault;
    logic             locked;
  } spc_stat_t;

endpackage

// ==== rtl/spc_filter.sv ====
// Two-flop synchroniser with a stable-level filter and fall detect
`timescale 1ns/1ps
`default_nettype none
module spc_filter #(
  parameter int STABLE = 1000,
  parameter bit INIT   = 1'b1
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic din,
  output logic      level,
  output logic      fall
);

  localparam int CW = $clog2(STABLE + 1);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          lvl;
    logic          fall;
    logic [CW-1:0] cnt;
  } spc_filt_st_t;

  spc_filt_st_t st_reg;
  spc_filt_st_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.s1   = din;
    st_next.s2   = st_reg.s1;
    st_next.fall = 1'b0;
    if (st_reg.s2 == st_reg.lvl) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == CW'(STABLE - 1)) begin
      // Level accepted only after it held steady, so contact bounce is ignored
      st_next.cnt  = '0;
      st_next.lvl  = st_reg.s2;
      st_next.fall = ~st_reg.s2;
    end else begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '{s1: INIT, s2: INIT, lvl: INIT, fall: 1'b0, cnt: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.lvl;
  assign fall  = st_reg.fall;

endmodule
`default_nettype wire

// ==== rtl/spc_counter.sv ====
// Single preset event counter: modes, timed output, remote clear, program lock
`timescale 1ns/1ps
`default_nettype none
module spc_counter #(
  parameter int DEB_CYC  = spc_pkg::DEB_CYC,
  parameter int FILT_CYC = spc_pkg::FILT_CYC,
  parameter int TICK_CYC = spc_pkg::TICK_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              pulse_input,
  input  wire logic              remote_clear_input,
  input  wire logic              program_lock_input,
  input  wire logic [3:0]        mode_sel,
  input  wire logic              store_ok,
  input  wire logic              store_done,
  input  wire logic [3:0]        dp_sel,
  input  wire logic              dp_load,
  input  wire spc_pkg::spc_keys_t keys,
  output logic                   out_on,
  output spc_pkg::spc_stat_t     status,
  output logic [spc_pkg::CNT_W-1:0] preset_val,
  output logic [spc_pkg::DUR_W-1:0] dur_val,
  output logic [3:0]             dp_val,
  output logic                   mode_bad
);

  localparam int TW = $clog2(TICK_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Inputs

  logic cnt_lvl;
  logic cnt_fall;
  logic clr_lvl;
  logic lock_lvl;

  spc_filter #(.STABLE(DEB_CYC), .INIT(1'b1)) u_cnt (
    .mclk  (mclk),
    .rst   (rst),
    .din   (pulse_input),
    .level (cnt_lvl),
    .fall  (cnt_fall)
  );

  spc_filter #(.STABLE(FILT_CYC), .INIT(1'b1)) u_clr (
    .mclk  (mclk),
    .rst   (rst),
    .din   (remote_clear_input),
    .level (clr_lvl),
    .fall  ()
  );

  // Lock pin reads as open at reset, so a fresh part is not shown locked before the filter settles
  spc_filter #(.STABLE(FILT_CYC), .INIT(1'b1)) u_lock (
    .mclk  (mclk),
    .rst   (rst),
    .din   (program_lock_input),
    .level (lock_lvl),
    .fall  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [spc_pkg::CNT_W-1:0] count;
    logic [spc_pkg::CNT_W-1:0] preset;
    logic [spc_pkg::DUR_W-1:0] dur;
    logic [spc_pkg::DUR_W-1:0] ticks;
    logic [TW-1:0]             sub;
    logic [3:0]                dp;
    logic [3:0]                mode;
    logic                      timing;
    logic                      latched;
    logic                      test;
    logic                      fault;
    logic                      checked;
    logic                      wait_end;
  } spc_st_t;

  spc_st_t st_reg;
  spc_st_t st_next;

  function automatic logic is_down(input logic [3:0] m);
    is_down = m[3];
  endfunction

  function automatic logic [spc_pkg::CNT_W-1:0] start_val(input logic [3:0] m,
                                                         input logic [spc_pkg::CNT_W-1:0] p);
    start_val = is_down(m) ? p : '0;
  endfunction

  function automatic logic mode_legal(input logic [3:0] m);
    mode_legal = (m == spc_pkg::SPC_MODE_UP_AUTO_AFTER) || (m == spc_pkg::SPC_MODE_DN_LATCH) ||
                 (m == spc_pkg::SPC_MODE_DN_TIMED_MAN) || (m == spc_pkg::SPC_MODE_DN_AUTO_AT) ||
                 (m == spc_pkg::SPC_MODE_DN_AUTO_AFTER);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic                      hit;
  logic [spc_pkg::CNT_W-1:0] stepped;
  logic                      unlocked;

  always_comb begin
    st_next  = st_reg;
    unlocked = lock_lvl;
    // Mode switches only sampled while clear is low, to avoid mid-cycle jumps; reset loads mode 6
    if (!clr_lvl && mode_legal(mode_sel)) begin
      st_next.mode = mode_sel;
    end

    // Setup edits, refused while locked
    if (unlocked && keys.load_preset) begin
      st_next.preset = keys.preset;
    end
    if (unlocked && keys.load_dur && keys.dur >= spc_pkg::DUR_MIN && keys.dur <= spc_pkg::DUR_MAX) begin
      st_next.dur = keys.dur;
    end
    if (unlocked && dp_load) begin
      st_next.dp = dp_sel;
    end
    st_next.test = keys.out_test & unlocked;

    // Power-up data check; fault only clears on enter
    if (!st_reg.checked && store_done) begin
      st_next.checked = 1'b1;
      st_next.fault   = ~store_ok;
    end else if (keys.ack_fault) begin
      st_next.fault = 1'b0;
    end

    // Duration timer in 10 ms ticks
    if (st_reg.timing) begin
      if (st_reg.sub == TW'(TICK_CYC - 1)) begin
        st_next.sub   = '0;
        st_next.ticks = st_reg.ticks + spc_pkg::DUR_W'(1);
        if (st_next.ticks >= st_reg.dur) begin
          st_next.timing = 1'b0;
        end
      end else begin
        st_next.sub = st_reg.sub + TW'(1);
      end
    end

    // Counting; the reload after a timed output keeps a count arriving in the same cycle
    stepped = is_down(st_reg.mode) ? st_reg.count - spc_pkg::CNT_W'(1) : st_reg.count + spc_pkg::CNT_W'(1);
    hit     = is_down(st_reg.mode) ? (stepped == '0) : (stepped == st_reg.preset);
    if (cnt_fall) begin
      st_next.count = stepped;
      if (hit && !st_reg.wait_end) begin
        unique case (st_reg.mode)
          spc_pkg::SPC_MODE_DN_LATCH: begin
            st_next.latched = 1'b1;
          end
          spc_pkg::SPC_MODE_DN_AUTO_AT: begin
            st_next.timing = 1'b1;
            st_next.ticks  = '0;
            st_next.sub    = '0;
            st_next.count  = st_reg.preset;
          end
          spc_pkg::SPC_MODE_UP_AUTO_AFTER, spc_pkg::SPC_MODE_DN_AUTO_AFTER: begin
            st_next.timing   = 1'b1;
            st_next.ticks    = '0;
            st_next.sub      = '0;
            st_next.wait_end = 1'b1;
          end
          default: begin
            st_next.timing = 1'b1;
            st_next.ticks  = '0;
            st_next.sub    = '0;
          end
        endcase
      end
    end

    // Auto reload once the timed output ends; counts since the hit are dropped
    if (st_reg.wait_end && !st_next.timing) begin
      st_next.wait_end = 1'b0;
      // Counts taken while timing are dropped; one landing on this very edge is kept
      st_next.count    = start_val(st_reg.mode, st_reg.preset);
      if (cnt_fall) begin
        st_next.count = is_down(st_reg.mode) ? st_reg.preset - spc_pkg::CNT_W'(1) : spc_pkg::CNT_W'(1);
      end
    end

    // Manual reset overrides counting and timed or latched output (not the output test) and holds while low
    if (!clr_lvl) begin
      st_next.count    = start_val(st_next.mode, st_next.preset);
      st_next.timing   = 1'b0;
      st_next.ticks    = '0;
      st_next.sub      = '0;
      st_next.latched  = 1'b0;
      st_next.wait_end = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '{count: '0, preset: spc_pkg::PRESET_DEFAULT, dur: spc_pkg::DUR_DEFAULT,
                  ticks: '0, sub: '0, dp: 4'h0, mode: spc_pkg::SPC_MODE_UP_AUTO_AFTER,
                  timing: 1'b0, latched: 1'b0, test: 1'b0, fault: 1'b0, checked: 1'b0,
                  wait_end: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign out_on         = st_reg.timing | st_reg.latched | st_reg.test;
  assign status.count   = st_reg.count;
  assign status.out     = st_reg.timing | st_reg.latched;
  assign status.fault   = st_reg.fault;
  assign status.locked  = ~lock_lvl;
  assign preset_val     = st_reg.preset;
  assign dur_val        = st_reg.dur;
  assign dp_val         = st_reg.dp;
  assign mode_bad       = ~mode_legal(mode_sel);

endmodule
`default_nettype wire

// ==== tb/spc_contacts.sv ====
// Far-side model: bouncing count contact, clear and lock switches
`timescale 1ns/1ps
`default_nettype none
module spc_contacts (
  input  wire logic mclk,
  output logic      pulse_input,
  output logic      remote_clear_input,
  output logic      program_lock_input
);
  // Pull-ups keep every open contact high
  initial begin
    pulse_input        = 1'b1;
    remote_clear_input = 1'b1;
    program_lock_input = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // Contact closure with one bounce at each end, then a long gap
  task automatic hit();
    @(posedge mclk) #1 pulse_input = 1'b0;
    @(posedge mclk) #1 pulse_input = 1'b1;
    @(posedge mclk) #1 pulse_input = 1'b0;
    repeat (20) @(posedge mclk);
    #1 pulse_input = 1'b1;
    @(posedge mclk) #1 pulse_input = 1'b0;
    @(posedge mclk) #1 pulse_input = 1'b1;
    repeat (20) @(posedge mclk);
    #1;
  endtask
  task automatic set_clear(input logic l);
    remote_clear_input = l;
  endtask
  task automatic set_lock(input logic l);
    program_lock_input = l;
  endtask
endmodule
`default_nettype wire

// ==== tb/spc_counter_asserts.sv ====
// Port checker of the single preset counter
`timescale 1ns/1ps
`default_nettype none
module spc_counter_asserts #(
  parameter int FILT_CYC = spc_pkg::FILT_CYC
) (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      remote_clear_input,
  input wire logic [3:0]                mode_sel,
  input wire logic                      store_done,
  input wire logic                      dp_load,
  input wire spc_pkg::spc_keys_t        keys,
  input wire logic                      out_on,
  input wire spc_pkg::spc_stat_t        status,
  input wire logic [spc_pkg::CNT_W-1:0] preset_val,
  input wire logic [spc_pkg::DUR_W-1:0] dur_val,
  input wire logic [3:0]                dp_val,
  input wire logic                      mode_bad
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Run of a low clear pin; the filter needs FILT_CYC cycles plus sync and register stages
  int clr_run_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clr_run_reg <= 0;
    end else if (remote_clear_input) begin
      clr_run_reg <= 0;
    end else if (clr_run_reg < FILT_CYC + 8) begin
      clr_run_reg <= clr_run_reg + 1;
    end
  end
  property p_clear_off; clr_run_reg >= FILT_CYC + 4 && !keys.out_test |=> !out_on; endproperty
  property p_clear_hold; clr_run_reg >= FILT_CYC + 4 |=> $stable(status.count); endproperty
  property p_lock_preset; status.locked && keys.load_preset |=> $stable(preset_val); endproperty
  property p_lock_dp; status.locked && dp_load |=> $stable(dp_val); endproperty
  property p_load_preset; !status.locked && keys.load_preset |=> preset_val == $past(keys.preset); endproperty
  property p_load_dur;
    !status.locked && keys.load_dur && keys.dur inside {[14'h0001:14'h270f]} |=> dur_val == $past(keys.dur);
  endproperty
  property p_dur_range; keys.load_dur && keys.dur == 14'h0000 |=> $stable(dur_val); endproperty
  property p_fault_ack; keys.ack_fault && !store_done |=> !status.fault; endproperty
  property p_mode_bad; mode_bad == !(mode_sel inside {4'h6, 4'h8, 4'h9, 4'hc, 4'he}); endproperty
  property p_out_test; !status.locked && keys.out_test |-> ##[1:2] out_on; endproperty
  a_clear_off: assert property (p_clear_off) else $error("output on under clear");
  a_clear_hold: assert property (p_clear_hold) else $error("count moved under clear");
  a_lock_preset: assert property (p_lock_preset) else $error("preset changed while locked");
  a_lock_dp: assert property (p_lock_dp) else $error("point changed while locked");
  a_load_preset: assert property (p_load_preset) else $error("preset not loaded");
  a_load_dur: assert property (p_load_dur) else $error("duration not loaded");
  a_dur_range: assert property (p_dur_range) else $error("zero duration taken");
  a_fault_ack: assert property (p_fault_ack) else $error("fault not cleared");
  a_mode_bad: assert property (p_mode_bad) else $error("mode flag wrong");
  a_out_test: assert property (p_out_test) else $error("output test ignored");
  c_load: cover property (keys.load_preset && !status.locked);
  c_out: cover property (out_on && !keys.out_test);
  c_fault: cover property (status.fault);
endmodule
bind spc_counter spc_counter_asserts #(.FILT_CYC(FILT_CYC)) u_chk (.mclk(mclk), .rst(rst),
  .remote_clear_input(remote_clear_input),
  .mode_sel(mode_sel), .store_done(store_done), .dp_load(dp_load), .keys(keys), .out_on(out_on),
  .status(status), .preset_val(preset_val), .dur_val(dur_val), .dp_val(dp_val), .mode_bad(mode_bad));
`default_nettype wire

// ==== tb/spc_counter_bench.sv ====
// Self-checking bench of the single preset counter
`timescale 1ns/1ps
`default_nettype none
module spc_counter_bench;
  logic                          mclk;
  logic                          rst;
  logic                          pulse_input, remote_clear_input, program_lock_input;
  logic [3:0]                    mode_sel;
  logic                          store_ok;
  logic                          store_done;
  logic [3:0]                    dp_sel;
  logic                          dp_load;
  spc_pkg::spc_keys_t            keys;
  logic                          out_on, mode_bad;
  spc_pkg::spc_stat_t            status;
  logic [spc_pkg::CNT_W-1:0]     preset_val;
  logic [spc_pkg::DUR_W-1:0]     dur_val;
  logic [3:0]                    dp_val;
  int                            n_errors = 0;
  int                            n_compared = 0;
  int                            cyc = 0;
  always #5 mclk = ~mclk;
  spc_contacts far (.mclk(mclk), .pulse_input(pulse_input), .remote_clear_input(remote_clear_input),
    .program_lock_input(program_lock_input));
  // Short filters keep the run small; durations then tick every 10 cycles
  spc_counter #(.DEB_CYC(4), .FILT_CYC(4), .TICK_CYC(10)) dut (.mclk(mclk), .rst(rst),
    .pulse_input(pulse_input), .remote_clear_input(remote_clear_input),
    .program_lock_input(program_lock_input), .mode_sel(mode_sel), .store_ok(store_ok),
    .store_done(store_done), .dp_sel(dp_sel), .dp_load(dp_load), .keys(keys), .out_on(out_on),
    .status(status), .preset_val(preset_val), .dur_val(dur_val), .dp_val(dp_val), .mode_bad(mode_bad));
  ////////////////////////////////////////////////////////////
  task wrap_up();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task load(input logic [19:0] p, input logic [13:0] d);
    keys.preset = p;
    keys.dur = d;
    keys.load_preset = 1'b1;
    keys.load_dur = 1'b1;
    tick(1);
    keys.load_preset = 1'b0;
    keys.load_dur = 1'b0;
    tick(1);
  endtask
  task dp(input logic [3:0] v);
    dp_sel = v;
    dp_load = 1'b1;
    tick(1);
    dp_load = 1'b0;
    tick(1);
  endtask
  // Mode is only taken while clear is held low
  task clr(input logic [3:0] m);
    mode_sel = m;
    far.set_clear(1'b0);
    tick(20);
    far.set_clear(1'b1);
    tick(20);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    mode_sel = 4'h6;
    store_ok = 1'b0;
    store_done = 1'b0;
    dp_sel = 4'h0;
    dp_load = 1'b0;
    keys = '0;
    tick(4);
    rst = 1'b0;
    tick(2);
    chk(dur_val, 14'h000a);
    store_done = 1'b1;
    tick(1);
    store_done = 1'b0;
    tick(2);
    chk(status.fault, 1'b1);
    keys.ack_fault = 1'b1;
    tick(1);
    keys.ack_fault = 1'b0;
    tick(1);
    chk(status.fault, 1'b0);
    load(20'h00002, 14'h0009);
    chk(preset_val, 20'h00002);
    load(20'h00002, 14'h0000);
    chk(dur_val, 14'h0009);
    dp(4'h3);
    chk(dp_val, 4'h3);
    far.set_lock(1'b0);
    tick(20);
    chk(status.locked, 1'b1);
    load(20'h00005, 14'h0005);
    dp(4'h1);
    chk(preset_val, 20'h00002);
    chk(dp_val, 4'h3);
    keys.out_test = 1'b1;
    tick(3);
    chk(out_on, 1'b0);
    keys.out_test = 1'b0;
    far.set_lock(1'b1);
    tick(20);
    keys.out_test = 1'b1;
    tick(3);
    chk(out_on, 1'b1);
    chk(status.out, 1'b0);
    keys.out_test = 1'b0;
    tick(3);
    for (int m = 0; m < 16; m++) begin
      mode_sel = m[3:0];
      tick(1);
      chk(mode_bad, !(m inside {6, 8, 9, 12, 14}));
    end
    clr(4'h8);
    chk(status.count, 20'h00002);
    far.set_clear(1'b0);
    far.hit();
    chk(status.count, 20'h00002);
    far.set_clear(1'b1);
    tick(20);
    far.hit();
    far.hit();
    chk(status.count, 20'h00000);
    chk(out_on, 1'b1);
    chk(status.out, 1'b1);
    far.hit();
    tick(100);
    chk(out_on, 1'b1);
    clr(4'h6);
    chk(out_on, 1'b0);
    chk(status.count, 20'h00000);
    far.hit();
    far.hit();
    chk(out_on, 1'b1);
    tick(80);
    chk(status.count, 20'h00000);
    chk(out_on, 1'b0);
    clr(4'hc);
    far.hit();
    far.hit();
    chk(status.count, 20'h00002);
    chk(out_on, 1'b1);
    clr(4'he);
    far.hit();
    far.hit();
    chk(status.count, 20'h00000);
    chk(out_on, 1'b1);
    tick(80);
    chk(status.count, 20'h00002);
    chk(out_on, 1'b0);
    clr(4'h9);
    far.hit();
    far.hit();
    chk(out_on, 1'b1);
    clr(4'h9);
    chk(out_on, 1'b0);
    chk(status.count, 20'h00002);
    far.hit();
    far.hit();
    tick(80);
    chk(out_on, 1'b0);
    chk(status.count, 20'h00000);
    // Second power-up with good stored data: no fault, factory duration, mode 6 from zero
    rst = 1'b1;
    store_ok = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    chk(dur_val, 14'h000a);
    chk(status.count, 20'h00000);
    chk(status.locked, 1'b0);
    store_done = 1'b1;
    tick(1);
    store_done = 1'b0;
    tick(2);
    chk(status.fault, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
